// ===== dm_stack_pkg.sv
package dm_stack_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] idx_ind_plain    = 8'h00;
    localparam logic [7:0] idx_ind_post_inc = 8'h01;
    localparam logic [7:0] idx_ind_post_dec = 8'h02;
    localparam logic [7:0] idx_ind_pre_inc  = 8'h03;
    localparam logic [7:0] idx_ind_offset   = 8'h04;
    localparam logic [7:0] idx_ptr_low      = 8'h10;
    localparam logic [7:0] idx_top_high     = 8'h16;
    localparam logic [7:0] idx_top_low      = 8'h17;
    localparam logic [7:0] idx_stack_ctl    = 8'h18;
    localparam logic [7:0] idx_pcl_high     = 8'h1a;
    localparam logic [7:0] idx_pcl_low      = 8'h1b;
    localparam logic [7:0] idx_bank_sel     = 8'h20;
    localparam logic [7:0] idx_working      = 8'h29;
    localparam logic [7:0] idx_proc_status  = 8'h2c;
    localparam logic [7:0] gpr_base         = 8'h80;
    // stack control and processor status field positions
    localparam int full_pos  = 7;
    localparam int under_pos = 6;
    localparam int over_pos  = 5;
    localparam int err_pos   = 2;
    localparam logic [2:0] level_max  = 3'h7;
    localparam logic [2:0] level_zero = 3'h0;
    localparam logic [10:0] pc_reset  = 11'h000;
    localparam logic [7:0] ctl_reset  = 8'h00;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_ack  = 2'b01
    } bus_state_e;

    typedef enum logic [1:0] {
        op_none = 2'b00,
        op_push = 2'b01,
        op_pop  = 2'b11,
        op_ret  = 2'b10
    } stack_op_e;

    typedef struct packed {
        logic       instr_valid;
        logic       dest_mem;
        logic       block_sel;
        logic [7:0] addr;
        logic [7:0] result;
    } instr_wr_s;
endpackage : dm_stack_pkg

// ===== data_memory_addressing_stack.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - stack_control bit 7 reads 1 once the stack has become full.
// - stack_control bit 6 reads 1 after a stack underflow.
// - stack_control bit 5 reads 1 after a stack overflow.
// - three-bit stack level pointer gives current stack level.
// - top-of-stack reads zero when the level pointer is zero.
// - top-of-stack as high byte bits 10..8 and low byte 7..0.
// - program counter latches high and low, cleared on every reset.
// - processor_status stack error flag set when stack error caused reset.
// - memory blocks of 256 bytes: low 128 special, upper 128 storage.
// - destination bit 0 writes working register, 1 writes memory.
// - block-access bit 0 always addresses block 0.
// - block-access bit 1: reduced core block 0, full core bank select.
// - undefined special addresses and unused bits read zero.
// - plain indirect port uses pointer, pointer unchanged.
// - post-increment port uses pointer then adds one.
// - post-decrement port uses pointer then subtracts one.
// - pre-increment port adds one then uses new pointer.
// - offset port addresses pointer plus signed working register.
// - pointer low byte readable and writable at index 0x10.
// - call pushes pc after incrementing level; return pops then decrements.
// - underflow forces pc to zero and level to zero.
// - overflow keeps last level and overwrites it, pc unchanged.
module data_memory_addressing_stack #(
    parameter bit   full_core       = 1'b0,
    parameter bit   stack_err_reset = 1'b0,
    parameter int   gpr_blocks      = 1
) (
    // system
    input  wire logic                   clock,
    input  wire logic                   nrst,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [31:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // core stack and instruction side
    input  wire logic [1:0]             stack_op,
    input  wire logic [10:0]            pc_in,
    input  wire dm_stack_pkg::instr_wr_s instr_wr,
    input  wire logic                   stack_err_rst,
    output logic      [10:0]            pc_out,
    output logic                        pc_load,
    output logic                        stack_reset_req
);
    localparam int mem_depth = 128 * gpr_blocks;
    localparam int mem_aw    = $clog2(mem_depth) + 1;

    typedef struct packed {
        dm_stack_pkg::bus_state_e bst;
        logic [31:0] rdata;
        logic        ack;
        logic [7:0]  ptr;
        logic [7:0]  working_accumulator;
        logic [3:0]  bank;
        logic [2:0]  level;
        logic        full;
        logic        under;
        logic        over;
        logic        err;
        logic [2:0]  pch;
        logic [7:0]  pcl;
        logic [10:0] pc_o;
        logic        pc_ld;
        logic        rst_req;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic [10:0] stk_r [1:7];
    logic [7:0]  gpr_r [0:mem_depth-1];

    logic        bus_req;
    logic [7:0]  idx;
    logic        wr_en;
    logic [7:0]  wbyte;
    logic [7:0]  eff_ptr;
    logic        ind_acc;
    logic        ind_gpr;
    logic [10:0] stack_top_value;
    logic        push_ev;
    logic [2:0]  push_lvl;
    logic        gpr_we;
    logic [7:0]  gpr_wa;
    logic [7:0]  gpr_wd;
    logic [3:0]  ins_blk;
    logic        ins_gpr;

    assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
    assign idx     = wb_adr_i[9:2];
    assign wr_en   = bus_req && wb_we_i && wb_sel_i[0];
    assign wbyte   = wb_dat_i[7:0];
    assign ind_acc = idx <= dm_stack_pkg::idx_ind_offset;
    assign stack_top_value = (s_r.level == dm_stack_pkg::level_zero) ? 11'h000
               : stk_r[s_r.level];

    always_comb begin
        eff_ptr = s_r.ptr;
        unique case (idx)
            dm_stack_pkg::idx_ind_pre_inc: eff_ptr = s_r.ptr + 8'h01;
            dm_stack_pkg::idx_ind_offset: eff_ptr = s_r.ptr + s_r.working_accumulator;
            default: eff_ptr = s_r.ptr;
        endcase
    end
    assign ind_gpr = eff_ptr[7];

    // instruction block select; only block 0 storage exists beyond bank 0 map
    always_comb begin
        ins_blk = 4'h0;
        if (instr_wr.block_sel && full_core) begin
            ins_blk = s_r.bank;
        end
    end
    assign ins_gpr = instr_wr.instr_valid && instr_wr.dest_mem
                   && instr_wr.addr[7]
                   && (int'(ins_blk) < gpr_blocks);

    always_comb begin
        gpr_we = 1'b0;
        gpr_wa = eff_ptr;
        gpr_wd = wbyte;
        if (wr_en && ind_acc && ind_gpr) begin
            gpr_we = 1'b1;
        end else if (ins_gpr) begin
            gpr_we = 1'b1;
            gpr_wa = instr_wr.addr;
            gpr_wd = instr_wr.result;
        end
    end

    function automatic logic [7:0] sr_read(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            dm_stack_pkg::idx_ptr_low:  v = s_r.ptr;
            dm_stack_pkg::idx_top_high: v = {5'h00, stack_top_value[10:8]};
            dm_stack_pkg::idx_top_low:  v = stack_top_value[7:0];
            dm_stack_pkg::idx_stack_ctl:
                v = {s_r.full, s_r.under, s_r.over, 2'b00, s_r.level};
            dm_stack_pkg::idx_pcl_high: v = {5'h00, s_r.pch};
            dm_stack_pkg::idx_pcl_low:  v = s_r.pcl;
            dm_stack_pkg::idx_bank_sel: v = {4'h0, s_r.bank};
            dm_stack_pkg::idx_working:  v = s_r.working_accumulator;
            dm_stack_pkg::idx_proc_status:
                v = {5'h00, s_r.err, 2'b00};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [7:0] rb;
        logic [2:0] lvl_up;
        rb = 8'h00;
        lvl_up = s_r.level + 3'h1;
        s_nxt = s_r;
        s_nxt.pc_ld = 1'b0;
        s_nxt.rst_req = 1'b0;
        push_ev = 1'b0;
        push_lvl = s_r.level;
        // bus handshake: answer one cycle after the request, drop next cycle
        unique case (s_r.bst)
            dm_stack_pkg::st_idle: begin
                s_nxt.ack = 1'b0;
                if (bus_req) begin
                    s_nxt.bst = dm_stack_pkg::st_ack;
                    s_nxt.ack = 1'b1;
                    if (ind_acc) begin
                        rb = ind_gpr ? gpr_r[eff_ptr[mem_aw-2:0]] : 8'h00;
                    end else if (!wb_we_i
                                 && idx == dm_stack_pkg::idx_pcl_low) begin
                        // low latch read returns the pc it snapshots
                        rb = pc_in[7:0];
                    end else begin
                        rb = sr_read(idx);
                    end
                    s_nxt.rdata = {24'h000000, rb};
                end
            end
            dm_stack_pkg::st_ack: begin
                s_nxt.bst = dm_stack_pkg::st_idle;
                s_nxt.ack = 1'b0;
            end
            default: begin
                s_nxt.bst = dm_stack_pkg::st_idle;
                s_nxt.ack = 1'b0;
            end
        endcase
        // pointer side effects of indirect ports, on read or write
        if (bus_req && wb_sel_i[0]) begin
            unique case (idx)
                dm_stack_pkg::idx_ind_post_inc: s_nxt.ptr = s_r.ptr + 8'h01;
                dm_stack_pkg::idx_ind_post_dec: s_nxt.ptr = s_r.ptr - 8'h01;
                dm_stack_pkg::idx_ind_pre_inc:  s_nxt.ptr = s_r.ptr + 8'h01;
                default: s_nxt.ptr = s_r.ptr;
            endcase
        end
        if (wr_en) begin
            unique case (idx)
                dm_stack_pkg::idx_ptr_low:  s_nxt.ptr = wbyte;
                dm_stack_pkg::idx_pcl_high: s_nxt.pch = wbyte[2:0];
                dm_stack_pkg::idx_pcl_low: begin
                    s_nxt.pcl = wbyte;
                    s_nxt.pc_o = {s_r.pch, wbyte};
                    s_nxt.pc_ld = 1'b1;
                end
                dm_stack_pkg::idx_bank_sel: s_nxt.bank = wbyte[3:0];
                dm_stack_pkg::idx_working:  s_nxt.working_accumulator = wbyte;
                dm_stack_pkg::idx_stack_ctl: begin
                    // flags clear by writing 0; a same-cycle event wins below
                    s_nxt.full  = s_r.full  & wbyte[dm_stack_pkg::full_pos];
                    s_nxt.under = s_r.under & wbyte[dm_stack_pkg::under_pos];
                    s_nxt.over  = s_r.over  & wbyte[dm_stack_pkg::over_pos];
                end
                dm_stack_pkg::idx_proc_status:
                    s_nxt.err = s_r.err & wbyte[dm_stack_pkg::err_pos];
                default: s_nxt.err = s_nxt.err;
            endcase
        end
        if (instr_wr.instr_valid && !instr_wr.dest_mem) begin
            s_nxt.working_accumulator = instr_wr.result;
        end
        // pc low read snapshots the high latch for a consistent pair
        if (bus_req && !wb_we_i && idx == dm_stack_pkg::idx_pcl_low) begin
            s_nxt.pcl = pc_in[7:0];
            s_nxt.pch = pc_in[10:8];
        end
        unique case (dm_stack_pkg::stack_op_e'(stack_op))
            dm_stack_pkg::op_push: begin
                push_ev = 1'b1;
                if (s_r.level == dm_stack_pkg::level_max) begin
                    s_nxt.over = 1'b1;
                    push_lvl = s_r.level;
                    s_nxt.rst_req = stack_err_reset;
                end else begin
                    push_lvl = lvl_up;
                    s_nxt.level = lvl_up;
                    if (lvl_up == dm_stack_pkg::level_max) begin
                        s_nxt.full = 1'b1;
                    end
                end
            end
            dm_stack_pkg::op_ret, dm_stack_pkg::op_pop: begin
                if (s_r.level == dm_stack_pkg::level_zero) begin
                    if (stack_op == dm_stack_pkg::op_ret) begin
                        s_nxt.under = 1'b1;
                        s_nxt.pc_o = dm_stack_pkg::pc_reset;
                        s_nxt.pc_ld = 1'b1;
                        s_nxt.rst_req = stack_err_reset;
                    end
                end else begin
                    if (stack_op == dm_stack_pkg::op_ret) begin
                        s_nxt.pc_o = stack_top_value;
                        s_nxt.pc_ld = 1'b1;
                    end
                    s_nxt.level = s_r.level - 3'h1;
                end
            end
            default: s_nxt.level = s_nxt.level;
        endcase
        if (stack_err_rst) begin
            s_nxt.err = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (push_ev && push_lvl != dm_stack_pkg::level_zero) begin
            stk_r[push_lvl] <= pc_in;
        end
        if (wr_en && idx == dm_stack_pkg::idx_top_low
            && s_r.level != dm_stack_pkg::level_zero) begin
            stk_r[s_r.level] <= {stk_r[s_r.level][10:8], wbyte};
        end
        if (gpr_we) begin
            gpr_r[gpr_wa[mem_aw-2:0]] <= gpr_wd;
        end
    end

    assign wb_dat_o        = s_r.rdata;
    assign wb_ack_o        = s_r.ack;
    assign pc_out          = s_r.pc_o;
    assign pc_load         = s_r.pc_ld;
    assign stack_reset_req = s_r.rst_req;
endmodule : data_memory_addressing_stack
`default_nettype wire

// ===== dm_stack_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dm_stack_asserts #(
    parameter bit stack_err_reset = 1'b0
) (
    // system
    input wire logic                    clock,
    input wire logic                    nrst,
    // wishbone
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [31:0]             wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    // core side
    input wire logic [1:0]              stack_op,
    input wire logic [10:0]             pc_in,
    input wire dm_stack_pkg::instr_wr_s instr_wr,
    input wire logic                    stack_err_rst,
    input wire logic [10:0]             pc_out,
    input wire logic                    pc_load,
    input wire logic                    stack_reset_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    a_high_zero: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("unused read bits set");
    a_ret_load: assert property (
        stack_op == dm_stack_pkg::op_ret |=> pc_load)
        else $error("return gave no pc load");
    a_load_cause: assert property (
        pc_load |-> $past(stack_op) == dm_stack_pkg::op_ret
                    || $past(wb_cyc_i && wb_we_i))
        else $error("pc load without cause");
    a_push_keep_pc: assert property (
        stack_op == dm_stack_pkg::op_push && !wb_we_i |=> !pc_load)
        else $error("push moved pc");
    a_pop_quiet: assert property (
        stack_op == dm_stack_pkg::op_pop && !wb_we_i |=> !pc_load)
        else $error("pop moved pc");
    a_no_reset_req: assert property (
        stack_reset_req |-> stack_err_reset) else $error("reset request");

    c_push: cover property (stack_op == dm_stack_pkg::op_push);
    c_load: cover property (pc_load);
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule : dm_stack_asserts
`default_nettype wire

// ===== cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    // clock
    input wire logic                clock,
    // toward the block
    output logic [1:0]              stack_op,
    output logic [10:0]             pc_in,
    output var dm_stack_pkg::instr_wr_s instr_wr,
    output logic                    stack_err_rst
);
    initial begin
        stack_op = 2'h0;
        pc_in = 11'h000;
        instr_wr = '0;
        stack_err_rst = 1'b0;
    end
    // one stack command for one cycle, pc held afterwards
    task op(input logic [1:0] o, input logic [10:0] p);
        @(posedge clock);
        stack_op <= o;
        pc_in <= p;
        @(posedge clock);
        stack_op <= 2'h0;
        @(posedge clock);
        // let the captured pc settle before the bench compares it
        @(negedge clock);
    endtask : op
    task iw(input logic d, b, input logic [7:0] a, r);
        @(posedge clock);
        instr_wr <= '{1'b1, d, b, a, r};
        @(posedge clock);
        instr_wr <= '{1'b0, ~d, ~b, ~a, ~r};
    endtask : iw
    task err;
        @(posedge clock);
        stack_err_rst <= 1'b1;
        @(posedge clock);
        stack_err_rst <= 1'b0;
    endtask : err
endmodule : cpu_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                    clock, nrst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic                    pc_load, reset_req, err_rst;
    logic [31:0]             wb_adr, wb_dat, wb_dat_o;
    logic [10:0]             pc_in, pc_out, last_pc;
    logic [1:0]              stack_op;
    logic [3:0]              wb_sel;
    logic [7:0]              q;
    dm_stack_pkg::instr_wr_s instr_wr;
    int                      err_total, n_checks, i;

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    data_memory_addressing_stack u_data_memory_addressing_stack (
        .clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack),
        .stack_op(stack_op), .pc_in(pc_in), .instr_wr(instr_wr),
        .stack_err_rst(err_rst), .pc_out(pc_out), .pc_load(pc_load),
        .stack_reset_req(reset_req));
    cpu_model u_cpu_model (.clock(clock), .stack_op(stack_op),
        .pc_in(pc_in), .instr_wr(instr_wr), .stack_err_rst(err_rst));

    always @(posedge clock) if (pc_load === 1'b1) last_pc <= pc_out;

    task results;
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
            err_total++;
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, d);
        int n;
        @(posedge clock);
        {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
        wb_sel <= 4'h1;
        wb_adr <= {22'h0, a, 2'b00};
        wb_dat <= {24'h0, d};
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            err_total++;
            results();
        end
        q = wb_dat_o[7:0];
        // ack stands up to this edge; release only after it
        @(posedge clock);
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
        wb_sel <= 4'h0;
    endtask : bus
    task rd(input logic [7:0] a, e);
        bus(1'b0, a, 8'h00);
        check(q, e);
    endtask : rd
    task wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask : wr

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        results();
    end

    initial begin
        {nrst, wb_cyc, wb_stb, wb_we} = 4'h0;
        {wb_adr, wb_dat, last_pc, err_total, n_checks, wb_sel} = '0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rd(dm_stack_pkg::idx_stack_ctl, 8'h00);
        rd(dm_stack_pkg::idx_pcl_high, 8'h00);
        rd(dm_stack_pkg::idx_top_low, 8'h00);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        wr(dm_stack_pkg::idx_ptr_low, 8'h80);
        wr(dm_stack_pkg::idx_ind_plain, 8'h11);
        rd(dm_stack_pkg::idx_ptr_low, 8'h80);
        rd(dm_stack_pkg::idx_ind_plain, 8'h11);
        wr(dm_stack_pkg::idx_ind_post_inc, 8'h22);
        wr(dm_stack_pkg::idx_ind_post_inc, 8'h33);
        wr(dm_stack_pkg::idx_ind_post_dec, 8'h44);
        rd(dm_stack_pkg::idx_ptr_low, 8'h81);
        rd(dm_stack_pkg::idx_ind_plain, 8'h33);
        rd(dm_stack_pkg::idx_ind_pre_inc, 8'h44);
        wr(dm_stack_pkg::idx_ptr_low, 8'h81);
        wr(dm_stack_pkg::idx_working, 8'hff);
        rd(dm_stack_pkg::idx_ind_offset, 8'h22);
        rd(dm_stack_pkg::idx_ptr_low, 8'h81);
        wr(dm_stack_pkg::idx_ptr_low, 8'h90);
        u_cpu_model.iw(1'b1, 1'b0, 8'h90, 8'h5a);
        u_cpu_model.iw(1'b0, 1'b0, 8'h90, 8'h3c);
        rd(dm_stack_pkg::idx_working, 8'h3c);
        rd(dm_stack_pkg::idx_ind_plain, 8'h5a);
        wr(dm_stack_pkg::idx_bank_sel, 8'h03);
        u_cpu_model.iw(1'b1, 1'b1, 8'h90, 8'h77);
        rd(dm_stack_pkg::idx_ind_plain, 8'h77);
        u_cpu_model.op(dm_stack_pkg::op_push, 11'h123);
        rd(dm_stack_pkg::idx_top_high, 8'h01);
        for (i = 2; i < 8; i++) begin
            u_cpu_model.op(dm_stack_pkg::op_push, 11'h100 + i[10:0]);
        end
        rd(dm_stack_pkg::idx_stack_ctl, 8'h87);
        u_cpu_model.op(dm_stack_pkg::op_push, 11'h555);
        rd(dm_stack_pkg::idx_stack_ctl, 8'ha7);
        rd(dm_stack_pkg::idx_top_low, 8'h55);
        for (i = 7; i > 0; i--) begin
            u_cpu_model.op(dm_stack_pkg::op_ret, 11'h000);
            check(last_pc, i == 7 ? 32'h555 : i == 1 ? 32'h123
                                  : 32'h100 + i);
        end
        rd(dm_stack_pkg::idx_top_high, 8'h00);
        u_cpu_model.op(dm_stack_pkg::op_pop, 11'h000);
        rd(dm_stack_pkg::idx_stack_ctl, 8'ha0);
        u_cpu_model.op(dm_stack_pkg::op_ret, 11'h000);
        check(last_pc, 11'h000);
        rd(dm_stack_pkg::idx_stack_ctl, 8'he0);
        wr(dm_stack_pkg::idx_stack_ctl, 8'h00);
        rd(dm_stack_pkg::idx_stack_ctl, 8'h00);
        u_cpu_model.err();
        rd(dm_stack_pkg::idx_proc_status, 8'h04);
        u_cpu_model.op(dm_stack_pkg::op_none, 11'h2ab);
        rd(dm_stack_pkg::idx_pcl_low, 8'hab);
        rd(dm_stack_pkg::idx_pcl_high, 8'h02);
        wr(dm_stack_pkg::idx_pcl_high, 8'h03);
        wr(dm_stack_pkg::idx_pcl_low, 8'h45);
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(last_pc, 11'h345);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(dm_stack_pkg::idx_pcl_high, 8'h00);
        results();
    end
endmodule : tb_top

bind data_memory_addressing_stack dm_stack_asserts #(
    .stack_err_reset(stack_err_reset)) u_dm_stack_asserts (
    .clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .stack_op(stack_op), .pc_in(pc_in), .instr_wr(instr_wr),
    .stack_err_rst(stack_err_rst), .pc_out(pc_out), .pc_load(pc_load),
    .stack_reset_req(stack_reset_req));
`default_nettype wire
